// ---- ptw_timer_watchdog.sv ----
// periodic timer and watchdog unit with apb register access
`timescale 1ns/1ps
module ptw_timer_watchdog
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic slow_clock,
	output logic timer_irq,
	output logic timer_underflow_pulse,
	output logic watchdog_reset_request
);
	import ptw_pkg::*;

	// ==========================================================
	// state
	// ==========================================================
	logic [5:0] config_bits;
	logic [2:0] prescale_divide_code;
	logic [15:0] reload, timer_count;
	logic [7:0] wd_count_value, wd_counter;
	logic [ptw_slow_sync_stages-1:0] slow_sync;
	logic [4:0] prescale_count;
	logic [11:0] error_hold;
	logic restart_pending, terminal_count_flag, timer_irq_enable, power_save, slow_prev;
	logic prescaled_tick, underflow_tick, wd_started, wd_match_seen, next_error;

	// apb decode
	logic access, wr, rd, active_ok, wd_tick, mapped;
	logic sel_config, sel_prescaler, sel_reload, sel_ctrl_stat, sel_count, sel_match, sel_mode, sel_status;
	logic svc_count, svc_match, bad_match;

	// divisor mask for a prescale code: tick when low bits of counter are all ones
	function automatic logic [4:0] ptw_div_mask(input logic [2:0] code);
		logic [5:0] full;
		full = 6'(6'h01 << code);
		ptw_div_mask = 5'(full - 6'h01);
	endfunction

	// ==========================================================
	// bus decode
	// ==========================================================
	// one-cycle access phase: the slave is always ready
	assign access = psel && penable;
	assign wr = access && pwrite;
	assign rd = access && !pwrite;
	assign active_ok = !power_save;
	assign sel_config = paddr == ptw_off_config;
	assign sel_prescaler = paddr == ptw_off_prescaler;
	assign sel_reload = paddr == ptw_off_reload;
	assign sel_ctrl_stat = paddr == ptw_off_ctrl_stat;
	assign sel_count = paddr == ptw_off_wd_count;
	assign sel_match = paddr == ptw_off_wd_match;
	assign sel_mode = paddr == ptw_off_power_mode;
	assign sel_status = paddr == ptw_off_status;
	assign mapped = sel_config || sel_prescaler || sel_reload || sel_ctrl_stat || sel_count || sel_match
		|| sel_mode || sel_status;

	// watchdog clock: prescaled tick or timer underflow
	assign wd_tick = config_bits[ptw_bit_watchdog_clock_select] ? prescaled_tick : underflow_tick;

	// service events
	assign svc_count = wr && sel_count && active_ok && !config_bits[ptw_bit_lock_watchdog_count];
	assign svc_match = wr && sel_match && config_bits[ptw_bit_match_service_enable];
	assign bad_match = svc_match && (pwdata[7:0] != ptw_match_value);

	// ==========================================================
	// registers
	// ==========================================================
	// set-only configuration; locked by its own bit 0
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			config_bits <= ptw_config_reset;
		else if (wr && sel_config && active_ok && !config_bits[ptw_bit_lock_config])
			config_bits <= config_bits | (pwdata[5:0] & ptw_config_used_mask);
	end

	// prescaler code; reserved codes are stored but divide as the largest
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prescale_divide_code <= ptw_prescale_reset;
		else if (wr && sel_prescaler && active_ok && !config_bits[ptw_bit_lock_prescaler])
			prescale_divide_code <= pwdata[2:0];
	end

	// reload value and timer control
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			reload <= ptw_reload_reset;
			timer_irq_enable <= 1'b0;
		end
		else if (wr && active_ok && !config_bits[ptw_bit_lock_periodic_timer])
		begin
			if (sel_reload)
				reload <= pwdata[15:0];
			if (sel_ctrl_stat)
				timer_irq_enable <= pwdata[ptw_bit_timer_irq_enable];
		end
	end

	// restart request: a write wins over a tick in the same cycle, so it is never lost
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			restart_pending <= 1'b0;
		else if (wr && sel_ctrl_stat && active_ok && !config_bits[ptw_bit_lock_periodic_timer]
			&& pwdata[ptw_bit_restart])
			restart_pending <= 1'b1;
		else if (prescaled_tick)
			restart_pending <= 1'b0;
	end

	// terminal count: cleared at the setup edge that captures it for reading; set wins
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			terminal_count_flag <= 1'b0;
		else if (underflow_tick)
			terminal_count_flag <= 1'b1;
		else if (psel && !penable && !pwrite && sel_ctrl_stat && active_ok
			&& !config_bits[ptw_bit_lock_periodic_timer])
			terminal_count_flag <= 1'b0;
	end

	// watchdog count value held for match servicing
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			wd_count_value <= ptw_wd_count_reset;
		else if (svc_count)
			wd_count_value <= pwdata[7:0];
	end

	// power-save mode flag, software controlled
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			power_save <= 1'b0;
		else if (wr && sel_mode)
			power_save <= pwdata[0];
	end

	// ==========================================================
	// slow clock and prescaler
	// ==========================================================
	// synchronise the slow clock; edge detect reads only the second stage
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			slow_sync <= '0;
			slow_prev <= 1'b0;
		end
		else
		begin
			slow_sync <= {slow_sync[0], slow_clock};
			slow_prev <= slow_sync[1];
		end
	end

	// power-of-two divider of slow clock rising edges
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prescale_count <= 5'h00;
			prescaled_tick <= 1'b0;
		end
		else
		begin
			prescaled_tick <= 1'b0;
			if (slow_sync[1] && !slow_prev)
			begin
				prescale_count <= prescale_count + 5'h01;
				// reserved codes fall back to divide by 32
				prescaled_tick <= (prescale_count & ptw_div_mask(prescale_divide_code > ptw_prescale_max_code
					? ptw_prescale_max_code : prescale_divide_code))
					== ptw_div_mask(prescale_divide_code > ptw_prescale_max_code
					? ptw_prescale_max_code : prescale_divide_code);
			end
		end
	end

	// ==========================================================
	// periodic timer
	// ==========================================================
	// counts down per prescaled tick, reloads on zero or restart
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			timer_count <= ptw_reload_reset;
			underflow_tick <= 1'b0;
		end
		else
		begin
			underflow_tick <= 1'b0;
			if (prescaled_tick)
			begin
				if (restart_pending)
					timer_count <= reload;
				else if (timer_count == 16'h0000)
					timer_count <= reload;
				else
				begin
					timer_count <= timer_count - 16'h0001;
					underflow_tick <= timer_count == 16'h0001;
				end
			end
		end
	end

	// underflow output held high for one prescaled cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			timer_underflow_pulse <= 1'b0;
		else if (underflow_tick)
			timer_underflow_pulse <= 1'b1;
		else if (prescaled_tick)
			timer_underflow_pulse <= 1'b0;
	end

	// interrupt follows the flag while enabled
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			timer_irq <= 1'b0;
		else
			timer_irq <= timer_irq_enable && (terminal_count_flag || underflow_tick);
	end

	// ==========================================================
	// watchdog
	// ==========================================================
	// started by the first service write, stops only on reset
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			wd_started <= 1'b0;
		else if (svc_count || svc_match)
			wd_started <= 1'b1;
	end

	// down counter, reloaded by a service
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			wd_counter <= ptw_wd_count_reset;
		else if (svc_count && !config_bits[ptw_bit_match_service_enable])
			wd_counter <= pwdata[7:0];
		else if (svc_match && !bad_match)
			wd_counter <= wd_count_value;
		else if (svc_count && !wd_started)
			wd_counter <= pwdata[7:0];
		else if (wd_started && wd_tick && wd_counter != 8'h00)
			wd_counter <= wd_counter - 8'h01;
	end

	// remembers a match write in the current watchdog clock cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			wd_match_seen <= 1'b0;
		else if (svc_match)
			wd_match_seen <= 1'b1;
		else if (wd_tick)
			wd_match_seen <= 1'b0;
	end

	// error sources: late service, repeated match, wrong match value
	assign next_error = (wd_started && wd_tick && wd_counter == 8'h00)
		|| (svc_match && wd_match_seen)
		|| bad_match;

	// stretched error pulse so slow reset logic catches it
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			error_hold <= 12'h000;
			watchdog_reset_request <= 1'b0;
		end
		else
		begin
			if (next_error)
				error_hold <= ptw_error_hold_cycles;
			else if (error_hold != 12'h000)
				error_hold <= error_hold - 12'h001;
			watchdog_reset_request <= next_error || error_hold > 12'h001;
		end
	end

	// ==========================================================
	// apb answer
	// ==========================================================
	// zero wait states; error for unmapped or mode-blocked access
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && (!mapped || (power_save && !sel_match && !sel_mode));
			prdata <= 32'h0000_0000;
			if (psel && !penable && !pwrite)
			begin
				if (sel_config)
					prdata <= config_bits[ptw_bit_lock_config] ? ptw_locked_read : {26'h0, config_bits};
				else if (sel_prescaler)
					prdata <= config_bits[ptw_bit_lock_prescaler] ? ptw_locked_read : {29'h0, prescale_divide_code};
				else if (sel_reload)
					prdata <= config_bits[ptw_bit_lock_periodic_timer] ? ptw_locked_read : {16'h0, reload};
				else if (sel_ctrl_stat)
					prdata <= config_bits[ptw_bit_lock_periodic_timer] ? ptw_locked_read
						: {29'h0, timer_irq_enable, terminal_count_flag, restart_pending};
				else if (sel_mode)
					prdata <= {31'h0, power_save};
				else if (sel_status)
					prdata <= {16'h0, wd_counter, 7'h0, wd_started};
			end
		end
	end
endmodule

// ---- ptw_pkg.sv ----
// constants and types shared by the periodic timer and watchdog unit
package ptw_pkg;
	// register byte offsets on the apb bus
	localparam logic [7:0] ptw_off_config = 8'h00;
	localparam logic [7:0] ptw_off_prescaler = 8'h04;
	localparam logic [7:0] ptw_off_reload = 8'h08;
	localparam logic [7:0] ptw_off_ctrl_stat = 8'h0C;
	localparam logic [7:0] ptw_off_wd_count = 8'h10;
	localparam logic [7:0] ptw_off_wd_match = 8'h14;
	localparam logic [7:0] ptw_off_power_mode = 8'h18;
	localparam logic [7:0] ptw_off_status = 8'h1C;
	// configuration bit positions
	localparam int ptw_bit_lock_config = 0;
	localparam int ptw_bit_lock_prescaler = 1;
	localparam int ptw_bit_lock_periodic_timer = 2;
	localparam int ptw_bit_lock_watchdog_count = 3;
	localparam int ptw_bit_watchdog_clock_select = 4;
	localparam int ptw_bit_match_service_enable = 5;
	localparam logic [5:0] ptw_config_used_mask = 6'h3F;
	// control/status bit positions
	localparam int ptw_bit_restart = 0;
	localparam int ptw_bit_terminal_count = 1;
	localparam int ptw_bit_timer_irq_enable = 2;
	// reset values, watchdog match value and largest prescale code
	localparam logic [5:0] ptw_config_reset = 6'h00;
	localparam logic [2:0] ptw_prescale_reset = 3'h0;
	localparam logic [15:0] ptw_reload_reset = 16'hFFFF;
	localparam logic [7:0] ptw_wd_count_reset = 8'h0F;
	localparam logic [7:0] ptw_match_value = 8'h5C;
	localparam logic [2:0] ptw_prescale_max_code = 3'h5;
	// value shown for locked register reads
	localparam logic [31:0] ptw_locked_read = 32'hDEAD_BEEF;
	// slow clock edge detection
	localparam int ptw_slow_sync_stages = 2;
	// watchdog error pulse: hold for at least one slow clock period (100 kHz min)
	localparam int ptw_slow_period_ns = 10000;
	localparam int ptw_clk_period_ns = 10;
	localparam logic [11:0] ptw_error_hold_cycles = 12'(ptw_slow_period_ns / ptw_clk_period_ns);
endpackage

// ---- ptw_asserts.sv ----
// port-level checks for the periodic timer and watchdog unit
`timescale 1ns/1ps
module ptw_asserts
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic slow_clock,
	input wire logic timer_irq,
	input wire logic timer_underflow_pulse,
	input wire logic watchdog_reset_request
);
	import ptw_pkg::*;
	// ==========
	// shadow state
	logic [5:0] lk;
	logic ie;
	logic acc;
	// only accepted transfers move the shadows, refused ones must not
	assign acc = psel && penable && pready && !pslverr;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			lk <= 6'h00;
		else if (acc && pwrite && paddr == ptw_off_config && !lk[0])
			lk <= lk | pwdata[5:0];
	end
	// irq enable follows unlocked control writes
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ie <= 1'b0;
		else if (acc && pwrite && paddr == ptw_off_ctrl_stat && !lk[2])
			ie <= pwdata[2];
	end
	// ==========
	// properties
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_ready;
		psel && !penable |=> pready;
	endproperty
	a_ready: assert property (p_ready) else $error("no ready after setup");
	property p_unmapped;
		psel && penable && pready && paddr > 8'h1C |-> pslverr;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
	property p_cfg_read;
		acc && !pwrite && paddr == ptw_off_config && !lk[0] |-> prdata == {26'h0, lk};
	endproperty
	a_cfg_read: assert property (p_cfg_read) else $error("config read differs");
	property p_cfg_locked;
		acc && !pwrite && paddr == ptw_off_config && lk[0] |-> prdata == ptw_locked_read;
	endproperty
	a_cfg_locked: assert property (p_cfg_locked) else $error("locked config readable");
	property p_pre_locked;
		acc && !pwrite && paddr == ptw_off_prescaler && lk[1] |-> prdata == ptw_locked_read;
	endproperty
	a_pre_locked: assert property (p_pre_locked) else $error("locked prescaler readable");
	property p_irq_off;
		!ie && !$past(ie) && !$past(ie, 2) |-> !timer_irq;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("irq while disabled");
	property p_err_hold;
		$rose(watchdog_reset_request) |=> watchdog_reset_request [*8];
	endproperty
	a_err_hold: assert property (p_err_hold) else $error("error pulse too short");
	property p_bad_match;
		acc && pwrite && paddr == ptw_off_wd_match && lk[5] && pwdata[7:0] != ptw_match_value
			|-> ##[1:4] watchdog_reset_request;
	endproperty
	a_bad_match: assert property (p_bad_match) else $error("bad match no error");
endmodule

bind ptw_timer_watchdog ptw_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.slow_clock(slow_clock), .timer_irq(timer_irq), .timer_underflow_pulse(timer_underflow_pulse),
	.watchdog_reset_request(watchdog_reset_request));

// ---- periodic_timer_watchdog_tb_top.sv ----
// self-checking bench for the periodic timer and watchdog unit
`timescale 1ns/1ps
`define CHK(nm, e, s) begin total_checks++; if ((s) !== (e)) begin num_errors++; \
	$display("wrong value %s exp %h got %h", nm, e, s); end end
module periodic_timer_watchdog_tb_top;
	import ptw_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slow_clock = 0, up_q = 0, lerr;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rv;
	logic pready, pslverr, timer_irq, timer_underflow_pulse, watchdog_reset_request;
	logic [63:0] expq[$];
	logic [63:0] hd;
	int num_errors = 0, total_checks = 0, cyc = 0, sdiv = 0, n;
	ptw_timer_watchdog dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.slow_clock(slow_clock), .timer_irq(timer_irq), .timer_underflow_pulse(timer_underflow_pulse),
		.watchdog_reset_request(watchdog_reset_request));
	initial forever #5 pclk = ~pclk;
	// ==========
	// slow clock of ten pclk, edge history and hang guard
	always @(posedge pclk)
	begin
		sdiv <= (sdiv == 4) ? 0 : sdiv + 1;
		if (sdiv == 4)
			slow_clock <= ~slow_clock;
		up_q <= timer_underflow_pulse;
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			num_errors++;
			give_verdict();
		end
	end
	// each completed read takes the oldest note: value and mask
	always @(posedge pclk)
		if (psel && penable && pready && !pwrite)
		begin
			hd = expq.pop_front();
			`CHK("prdata", hd[63:32] & hd[31:0], prdata & hd[31:0])
		end
	// ==========
	// tasks
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m = 32'hFFFF_FFFF);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		if (!w)
			expq.push_back({d, m});
		@(posedge pclk);
		penable <= 1;
		// no timeout of its own: pready ends this wait, else only the bench's cycle ceiling does
		do
			@(posedge pclk);
		while (!pready);
		lerr = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	// waits for the error level or an underflow rise, bounded
	task automatic wait_for(input bit err, input int lim, output int c);
		c = 0;
		do
		begin
			@(posedge pclk);
			c++;
		end
		while (!(err ? watchdog_reset_request : timer_underflow_pulse && !up_q) && c < lim);
	endtask
	task automatic rst(input int c);
		presetn <= 0;
		repeat (c) @(posedge pclk);
		presetn <= 1;
	endtask
	task automatic done(input string s);
		$display("test %s ended, errors %0d", s, num_errors);
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// ==========
	// scenarios
	initial
	begin
		void'($urandom(96405));
		rst(10);
		apb(0, ptw_off_config, 0);
		apb(0, ptw_off_reload, 32'h0000_FFFF);
		apb(0, ptw_off_ctrl_stat, 0);
		apb(0, 8'h20, 0, 0);
		`CHK("unmapped", 1'b1, lerr)
		apb(1, ptw_off_power_mode, 1);
		apb(1, ptw_off_reload, 32'h0000_1234);
		`CHK("save refused", 1'b1, lerr)
		apb(1, ptw_off_wd_match, 0);
		`CHK("save match", 1'b0, lerr)
		apb(1, ptw_off_power_mode, 0);
		apb(0, ptw_off_reload, 32'h0000_FFFF);
		for (int i = 0; i < 8; i++)
		begin
			apb(1, ptw_off_prescaler, 32'(i));
			apb(0, ptw_off_prescaler, 32'(i));
		end
		rv = 32'($urandom_range(16'hFFFF, 1));
		apb(1, ptw_off_reload, rv);
		apb(0, ptw_off_reload, rv);
		done("registers");
		// underflow every reload+1 prescaled ticks
		apb(1, ptw_off_prescaler, 0);
		apb(1, ptw_off_reload, 3);
		apb(1, ptw_off_ctrl_stat, 32'h0000_0005);
		wait_for(0, 5000, n);
		@(posedge pclk);
		`CHK("irq on", 1'b1, timer_irq)
		apb(0, ptw_off_ctrl_stat, 32'h0000_0006);
		apb(0, ptw_off_ctrl_stat, 32'h0000_0004);
		apb(1, ptw_off_ctrl_stat, 32'h0000_0002);
		apb(0, ptw_off_ctrl_stat, 0);
		wait_for(0, 5000, n);
		@(posedge pclk);
		`CHK("irq off", 1'b0, timer_irq)
		// the extra edge above would shorten the count, so measure rise to rise
		wait_for(0, 5000, n);
		wait_for(0, 5000, n);
		`CHK("gap div1", 40, n)
		apb(1, ptw_off_prescaler, 2);
		wait_for(0, 5000, n);
		wait_for(0, 5000, n);
		`CHK("gap div4", 160, n)
		apb(1, ptw_off_config, 32'h0000_0010);
		apb(1, ptw_off_config, 0);
		apb(0, ptw_off_config, 32'h0000_0010);
		done("timer");
		// count servicing, then let it run late
		apb(1, ptw_off_prescaler, 0);
		for (int i = 0; i < 8; i++)
		begin
			apb(1, ptw_off_wd_count, 3);
			repeat (12) @(posedge pclk);
		end
		`CHK("early", 1'b0, watchdog_reset_request)
		wait_for(1, 200, n);
		`CHK("late", 1'b1, n >= 15 && n <= 40)
		// match servicing, then a wrong value or too many writes
		for (int k = 0; k < 2; k++)
		begin
			rst(2);
			apb(1, ptw_off_config, 32'h0000_0030);
			apb(1, ptw_off_wd_count, 5);
			for (int i = 0; i < 6; i++)
			begin
				apb(1, ptw_off_wd_match, 32'(ptw_match_value));
				repeat (16) @(posedge pclk);
			end
			`CHK("served", 1'b0, watchdog_reset_request)
			if (k == 0)
				apb(1, ptw_off_wd_match, 32'h0000_005B);
			else
				repeat (3) apb(1, ptw_off_wd_match, 32'(ptw_match_value));
			wait_for(1, 20, n);
			`CHK("match error", 1'b1, watchdog_reset_request)
		end
		rst(2);
		apb(1, ptw_off_config, 32'h0000_0010);
		apb(1, ptw_off_wd_count, 8);
		apb(1, ptw_off_wd_match, 0);
		wait_for(1, 50, n);
		`CHK("match ignored", 1'b0, watchdog_reset_request)
		// watchdog on the underflow clock: three underflows of 40 cycles before the error
		rst(2);
		apb(1, ptw_off_reload, 3);
		apb(1, ptw_off_ctrl_stat, 1);
		apb(1, ptw_off_wd_count, 2);
		wait_for(1, 60, n);
		`CHK("not on prescaled clock", 1'b0, watchdog_reset_request)
		wait_for(1, 100, n);
		`CHK("underflow clock error", 1'b1, watchdog_reset_request)
		done("watchdog");
		// locks: reads give the filler, count writes dropped
		rst(2);
		apb(1, ptw_off_config, 32'h0000_003F);
		apb(0, ptw_off_config, ptw_locked_read);
		apb(1, ptw_off_prescaler, 5);
		apb(0, ptw_off_prescaler, ptw_locked_read);
		apb(0, ptw_off_reload, ptw_locked_read);
		apb(0, ptw_off_ctrl_stat, ptw_locked_read);
		apb(1, ptw_off_wd_count, 1);
		wait_for(1, 300, n);
		`CHK("count locked", 1'b0, watchdog_reset_request)
		done("locks");
		give_verdict();
	end
endmodule
